// ### hdl/cmie_defines.vh
/*
 * Constants of the CPU module interrupt and error-status block:
 * register offsets, bit positions, field widths.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef CMIE_DEFINES_VH
`define CMIE_DEFINES_VH

`define CMIE_AW            16
`define CMIE_DW            32
`define CMIE_OFF_EN0       16'h1100
`define CMIE_OFF_EN1       16'h1140
`define CMIE_OFF_SRC0      16'h1180
`define CMIE_OFF_SRC1      16'h11C0
`define CMIE_OFF_DERR      16'h1540
`define CMIE_OFF_MERR      16'h1580
`define CMIE_OFF_CTL       16'h1600

`define CMIE_EN_BITS       9
`define CMIE_EN_CTLP       8
`define CMIE_EN_HALT       7
`define CMIE_EN_TIMER      6
`define CMIE_EN_IP         5
`define CMIE_EN_L17        4
`define CMIE_EN_L16        3
`define CMIE_EN_L15        2
`define CMIE_EN_L14        1
`define CMIE_EN_UART       0

`define CMIE_SRC_HALT      28
`define CMIE_SRC_CTLP      27
`define CMIE_SRC_L17_LO    22
`define CMIE_SRC_L16_LO    17
`define CMIE_SRC_L15_LO    12
`define CMIE_SRC_L14_LO    7
`define CMIE_SRC_TIMER     6
`define CMIE_SRC_IP        5
`define CMIE_SRC_OR_LO     1
`define CMIE_SRC_UART      0

`define CMIE_NODES         5
`define CMIE_LEVELS        4

`define CMIE_DERR_GENERAL_BUS_TIMEOUT_FLAG     2
`define CMIE_DERR_CPE0     1
`define CMIE_DERR_A2D      0
`define CMIE_DERR_BITS     3

`define CMIE_MERR_RST      6
`define CMIE_MERR_CPE3     5
`define CMIE_MERR_CPE2     4
`define CMIE_MERR_CPE1     3
`define CMIE_MERR_D2M      2
`define CMIE_MERR_AP1      1
`define CMIE_MERR_AP0      0
`define CMIE_MERR_BITS     7

`define CMIE_CTL_FRIGN     0
`define CMIE_ZERO32        32'h00000000

`endif

// ### hdl/cmie_sticky.v
/*
 * Bank of sticky flags: hardware sets, software clears by writing one.
 * Assumes set pulses and clear strobe synchronous to ref_clk.
 */
`timescale 1ns/100ps
`default_nettype none

module cmie_sticky #(
   parameter N = 8
) (
   input  wire         ref_clk,  // system clock
   input  wire         rst_n,    // async reset
   input  wire [N-1:0] set,      // per-bit set events
   input  wire         clr_we,   // write strobe to this register
   input  wire [N-1:0] clr_data, // write data, ones clear
   output reg  [N-1:0] flags     // latched flags
);

   // Set wins over a same-cycle clear so no event is lost
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         flags <= {N{1'b0}};
      end else begin
         flags <= (flags & ~({N{clr_we}} & clr_data)) | set;
      end
   end

endmodule

`default_nettype wire

// ### hdl/cmie_top.v
/*
 * CPU module interrupt and error-status logic: one enable and one
 * source register per CPU, two error registers, request lines to
 * both processor cores. Assumes all inputs synchronous to ref_clk
 * and a simple strobe register port, read data one cycle later.
 */
`timescale 1ns/100ps
`default_nettype none
`include "cmie_defines.vh"

module cmie_top (
   input  wire        ref_clk,          // 100 MHz system clock
   input  wire        rst_n,            // async reset, active low
   input  wire [15:0] reg_addr,         // register byte offset
   input  wire [31:0] reg_wdata,        // write data
   input  wire        reg_we,           // write strobe
   input  wire        reg_re,           // read strobe
   output reg  [31:0] reg_rdata,        // read data, cycle after strobe
   input  wire        gbus_read,        // Gbus read issued, pulse
   input  wire        gbus_ack,         // Gbus acknowledge, pulse
   input  wire [4:0]  node_l17,         // per-node level 17, nodes 8..4
   input  wire [4:0]  node_l16,         // per-node level 16
   input  wire [4:0]  node_l15,         // per-node level 15
   input  wire [4:0]  node_l14,         // per-node level 14
   input  wire        timer_irq,        // interval timer line, level
   input  wire        uart_irq,         // console UART line, level
   input  wire [1:0]  ip_set,           // interprocessor request per CPU
   input  wire        ctlp_halt,        // control-P halt from Gbus, pulse
   input  wire        secure,           // secure bit of misc register
   input  wire [1:0]  halt_write,       // halt bit written per CPU, pulse
   input  wire        node_reset_write, // node reset bit written, pulse
   input  wire        power_fail,       // power fail from module, level
   input  wire [4:0]  csr_valid,        // CSR-valid: gates 0..3, memgate 4
   input  wire [4:0]  dm_to_gate,       // self/data move to gate 0..3, mem 4
   input  wire [4:0]  csr_perr,         // raw CSR parity: gates 0..3, mem 4
   input  wire        addr_gate_csr_bus_driven,      // address gate drives its CSR bus
   input  wire        addr_gate_csr_bus_perr,        // raw parity on that bus
   input  wire [1:0]  apath_driven,     // address gate drives CPU path
   input  wire [1:0]  apath_perr,       // raw address path parity
   output reg  [3:0]  cpu0_irq,         // CPU0 levels 17..14 on 3..0
   output reg  [3:0]  cpu1_irq,         // CPU1 levels 17..14 on 3..0
   output reg  [1:0]  machine_check_request, // per CPU
   output reg  [1:0]  halt_request,     // per CPU
   output reg  [1:0]  power_fail_request, // per CPU
   output reg         bus_data_timeout, // bus data timeout pulse
   output reg         sys_fault         // system fault, level
);

   parameter GENERAL_BUS_TIMEOUT_FLAG_NS = 100000;          // Gbus timeout, ns
   parameter CLK_NS  = 10;              // ref_clk period, ns
   localparam GENERAL_BUS_TIMEOUT_FLAG_CYC = GENERAL_BUS_TIMEOUT_FLAG_NS / CLK_NS;

   // Register address decode for the write strobes; reads decode in the read mux
   function hit;
      input [15:0] a;
      input [15:0] off;
      begin
         hit = (a == off);
      end
   endfunction

   wire we_en0  = reg_we & hit(reg_addr, `CMIE_OFF_EN0);
   wire we_en1  = reg_we & hit(reg_addr, `CMIE_OFF_EN1);
   wire we_src0 = reg_we & hit(reg_addr, `CMIE_OFF_SRC0);
   wire we_src1 = reg_we & hit(reg_addr, `CMIE_OFF_SRC1);
   wire we_derr = reg_we & hit(reg_addr, `CMIE_OFF_DERR);
   wire we_merr = reg_we & hit(reg_addr, `CMIE_OFF_MERR);
   wire we_ctl  = reg_we & hit(reg_addr, `CMIE_OFF_CTL);

   reg [`CMIE_EN_BITS-1:0] en0;
   reg [`CMIE_EN_BITS-1:0] en1;
   reg                     force_ignore;

   // Enable registers per CPU, force-ignore diagnostic bit
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         en0          <= 9'h000;
         en1          <= 9'h000;
         force_ignore <= 1'b0;
      end else begin
         if (we_en0) begin
            en0 <= reg_wdata[`CMIE_EN_BITS-1:0];
         end
         if (we_en1) begin
            en1 <= reg_wdata[`CMIE_EN_BITS-1:0];
         end
         if (we_ctl) begin
            force_ignore <= reg_wdata[`CMIE_CTL_FRIGN];
         end
      end
   end

   // Gbus timeout counter; a late ack after timeout is ignored
   reg [31:0] general_bus_timeout_flag_cnt;
   reg        general_bus_timeout_flag_busy;
   reg        general_bus_timeout_flag_hit;
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         general_bus_timeout_flag_cnt  <= `CMIE_ZERO32;
         general_bus_timeout_flag_busy <= 1'b0;
         general_bus_timeout_flag_hit  <= 1'b0;
      end else begin
         general_bus_timeout_flag_hit <= 1'b0;
         if (gbus_read) begin
            general_bus_timeout_flag_busy <= 1'b1;
            general_bus_timeout_flag_cnt  <= `CMIE_ZERO32;
         end else if (general_bus_timeout_flag_busy) begin
            if (gbus_ack) begin
               general_bus_timeout_flag_busy <= 1'b0;
            end else if (general_bus_timeout_flag_cnt == GENERAL_BUS_TIMEOUT_FLAG_CYC - 1) begin
               general_bus_timeout_flag_busy <= 1'b0;
               general_bus_timeout_flag_hit  <= 1'b1;
            end else begin
               general_bus_timeout_flag_cnt <= general_bus_timeout_flag_cnt + 32'h00000001;
            end
         end
      end
   end

   // Qualified error events: parity counts only inside its window
   wire [`CMIE_DERR_BITS-1:0] derr_set;
   assign derr_set[`CMIE_DERR_GENERAL_BUS_TIMEOUT_FLAG] = general_bus_timeout_flag_hit;
   assign derr_set[`CMIE_DERR_CPE0] =
      csr_perr[0] & (csr_valid[0] | dm_to_gate[0]);
   assign derr_set[`CMIE_DERR_A2D] = addr_gate_csr_bus_perr & addr_gate_csr_bus_driven;

   wire [2:0] gate_perr = csr_perr[3:1] & (csr_valid[3:1] | dm_to_gate[3:1]);
   wire [`CMIE_MERR_BITS-1:0] merr_set;
   assign merr_set[`CMIE_MERR_RST] = node_reset_write;
   assign merr_set[`CMIE_MERR_CPE3:`CMIE_MERR_CPE1] = gate_perr;
   // Memory gate sits at index 4 of the qualifier vectors
   assign merr_set[`CMIE_MERR_D2M] = 1'b0;
   assign merr_set[`CMIE_MERR_AP1] = apath_perr[1] & apath_driven[1];
   assign merr_set[`CMIE_MERR_AP0] = apath_perr[0] & apath_driven[0];

   wire [`CMIE_DERR_BITS-1:0] derr;
   wire [`CMIE_MERR_BITS-1:0] merr;

   // Sticky error registers, write one to clear
   cmie_sticky #(.N(`CMIE_DERR_BITS)) u_derr (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .set      (derr_set),
      .clr_we   (we_derr),
      .clr_data (reg_wdata[`CMIE_DERR_BITS-1:0]),
      .flags    (derr)
   );

   cmie_sticky #(.N(`CMIE_MERR_BITS)) u_merr (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .set      (merr_set),
      .clr_we   (we_merr),
      .clr_data (reg_wdata[`CMIE_MERR_BITS-1:0]),
      .flags    (merr)
   );

   // Memory-gate CSR parity at bit 2 kept apart for its own qualifier
   reg d2m_flag;
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         d2m_flag <= 1'b0;
      end else begin
         d2m_flag <= (d2m_flag & ~(we_merr & reg_wdata[`CMIE_MERR_D2M]))
                     | (csr_perr[4] & (csr_valid[4] | dm_to_gate[4]));
      end
   end

   wire [`CMIE_MERR_BITS-1:0] merr_view =
      merr | ({{(`CMIE_MERR_BITS-1){1'b0}}, d2m_flag} << `CMIE_MERR_D2M);

   // Latched per-CPU sources; set beats clear in the same cycle
   reg [1:0] timer_lat;
   reg [1:0] uart_lat;
   reg [1:0] ip_lat;
   reg [1:0] ctlp_lat;
   reg [1:0] halt_lat;
   reg       timer_d;
   reg       uart_d;
   wire      timer_rise = timer_irq & ~timer_d;
   wire      uart_rise  = uart_irq & ~uart_d;
   wire [1:0] we_src = {we_src1, we_src0};
   wire [1:0] en_halt = {en1[`CMIE_EN_HALT], en0[`CMIE_EN_HALT]};
   wire [1:0] en_ctlp = {en1[`CMIE_EN_CTLP], en0[`CMIE_EN_CTLP]};

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         timer_d <= 1'b0;
         uart_d  <= 1'b0;
      end else begin
         timer_d <= timer_irq;
         uart_d  <= uart_irq;
      end
   end

   genvar c;
   generate
      for (c = 0; c < 2; c = c + 1) begin : g_cpu
         wire clr_tm = we_src[c] & reg_wdata[`CMIE_SRC_TIMER];
         wire clr_ua = we_src[c] & reg_wdata[`CMIE_SRC_UART];
         wire clr_ip = we_src[c] & reg_wdata[`CMIE_SRC_IP];
         wire clr_cp = we_src[c] & reg_wdata[`CMIE_SRC_CTLP];
         wire clr_hl = we_src[c] & reg_wdata[`CMIE_SRC_HALT];
         always @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               timer_lat[c] <= 1'b0;
               uart_lat[c]  <= 1'b0;
               ip_lat[c]    <= 1'b0;
               ctlp_lat[c]  <= 1'b0;
               halt_lat[c]  <= 1'b0;
            end else begin
               timer_lat[c] <= (timer_lat[c] & ~clr_tm) | timer_rise;
               uart_lat[c]  <= (uart_lat[c] & ~clr_ua) | uart_rise;
               ip_lat[c]    <= (ip_lat[c] & ~clr_ip) | ip_set[c];
               ctlp_lat[c]  <= (ctlp_lat[c] & ~clr_cp)
                               | (ctlp_halt & ~secure & en_ctlp[c]);
               // Halt report only with the enable set
               halt_lat[c]  <= (halt_lat[c] & ~clr_hl)
                               | (halt_write[c] & en_halt[c]);
            end
         end
      end
   endgenerate

   // Level summaries, OR of the per-node bits
   wire [3:0] lvl_any = {|node_l17, |node_l16, |node_l15, |node_l14};

   // Source register image for one CPU
   function [31:0] src_img;
      input hl;
      input cp;
      input tm;
      input ip;
      input ua;
      begin
         src_img = `CMIE_ZERO32;
         src_img[`CMIE_SRC_HALT] = hl;
         src_img[`CMIE_SRC_CTLP] = cp;
         src_img[`CMIE_SRC_L17_LO +: `CMIE_NODES] = node_l17;
         src_img[`CMIE_SRC_L16_LO +: `CMIE_NODES] = node_l16;
         src_img[`CMIE_SRC_L15_LO +: `CMIE_NODES] = node_l15;
         src_img[`CMIE_SRC_L14_LO +: `CMIE_NODES] = node_l14;
         src_img[`CMIE_SRC_TIMER] = tm;
         src_img[`CMIE_SRC_IP] = ip;
         src_img[`CMIE_SRC_OR_LO +: `CMIE_LEVELS] = lvl_any;
         src_img[`CMIE_SRC_UART] = ua;
      end
   endfunction

   wire [31:0] src0 = src_img(halt_lat[0], ctlp_lat[0], timer_lat[0],
                              ip_lat[0], uart_lat[0]);
   wire [31:0] src1 = src_img(halt_lat[1], ctlp_lat[1], timer_lat[1],
                              ip_lat[1], uart_lat[1]);

   // Request lines per CPU; timer, IP and UART share level 14 pin
   function [3:0] irq_map;
      input [8:0] en;
      input       tm;
      input       ip;
      input       ua;
      reg         low;
      begin
         low = (lvl_any[0] & en[`CMIE_EN_L14])
             | (ua & en[`CMIE_EN_UART])
             | (tm & en[`CMIE_EN_TIMER])
             | (ip & en[`CMIE_EN_IP]);
         irq_map = {lvl_any[3] & en[`CMIE_EN_L17],
                    lvl_any[2] & en[`CMIE_EN_L16],
                    lvl_any[1] & en[`CMIE_EN_L15], low};
      end
   endfunction

   wire fatal = derr[`CMIE_DERR_GENERAL_BUS_TIMEOUT_FLAG] | merr_view[`CMIE_MERR_AP1]
              | merr_view[`CMIE_MERR_AP0];
   wire mchk  = fatal | derr[`CMIE_DERR_CPE0] | derr[`CMIE_DERR_A2D]
              | merr_view[`CMIE_MERR_CPE3] | merr_view[`CMIE_MERR_CPE2]
              | merr_view[`CMIE_MERR_CPE1]
              | merr_view[`CMIE_MERR_D2M];

   // Processor pins registered
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cpu0_irq              <= 4'h0;
         cpu1_irq              <= 4'h0;
         machine_check_request <= 2'h0;
         halt_request          <= 2'h0;
         power_fail_request    <= 2'h0;
         bus_data_timeout      <= 1'b0;
         sys_fault             <= 1'b0;
      end else begin
         cpu0_irq <= irq_map(en0, timer_lat[0], ip_lat[0], uart_lat[0]);
         cpu1_irq <= irq_map(en1, timer_lat[1], ip_lat[1], uart_lat[1]);
         machine_check_request <= {mchk, mchk};
         halt_request <= halt_lat | ctlp_lat;
         power_fail_request <= {power_fail, power_fail};
         bus_data_timeout <= general_bus_timeout_flag_hit & ~force_ignore;
         sys_fault <= derr[`CMIE_DERR_GENERAL_BUS_TIMEOUT_FLAG] & ~force_ignore;
      end
   end

   // Read mux; unmapped addresses and reserved bits read zero
   reg [31:0] next_rdata;
   always @* begin
      next_rdata = `CMIE_ZERO32;
      case (reg_addr)
         `CMIE_OFF_EN0:  next_rdata[`CMIE_EN_BITS-1:0] = en0;
         `CMIE_OFF_EN1:  next_rdata[`CMIE_EN_BITS-1:0] = en1;
         `CMIE_OFF_SRC0: next_rdata = src0;
         `CMIE_OFF_SRC1: next_rdata = src1;
         `CMIE_OFF_DERR: next_rdata[`CMIE_DERR_BITS-1:0] = derr;
         `CMIE_OFF_MERR: next_rdata[`CMIE_MERR_BITS-1:0] = merr_view;
         `CMIE_OFF_CTL:  next_rdata[`CMIE_CTL_FRIGN] = force_ignore;
         default:        next_rdata = `CMIE_ZERO32;
      endcase
   end

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= `CMIE_ZERO32;
      end else if (reg_re) begin
         reg_rdata <= next_rdata;
      end else begin
         reg_rdata <= `CMIE_ZERO32;
      end
   end

endmodule

`default_nettype wire

// ### dv/cmie_chk.sv
/*
 * Checker for the interrupt and error-status block: request lines,
 * read slot, timeout and machine-check timing.
 * Assumes a bind to cmie_top, one clock, async active-low reset.
 */
`timescale 1ns/100ps
`default_nettype none

module cmie_chk (
   input wire logic        ref_clk,               // system clock
   input wire logic        rst_n,                 // async reset
   input wire logic        reg_re,                // read strobe
   input wire logic [31:0] reg_rdata,             // read data
   input wire logic [4:0]  node_l17,              // level 17 nodes
   input wire logic [1:0]  apath_driven,          // address path driven
   input wire logic [1:0]  apath_perr,            // address path parity
   input wire logic        power_fail,            // power fail in
   input wire logic [3:0]  cpu0_irq,              // CPU0 requests
   input wire logic [3:0]  cpu1_irq,              // CPU1 requests
   input wire logic [1:0]  machine_check_request, // machine check
   input wire logic [1:0]  power_fail_request,    // power fail out
   input wire logic        bus_data_timeout,      // timeout pulse
   input wire logic        sys_fault              // system fault
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   // Registered lines may trail their cause by up to two cycles
   a_rdata_idle: assert property (
      reg_rdata != 32'h0 |-> $past(reg_re))
      else $error("read data outside read slot");
   a_l17_pin: assert property (
      cpu0_irq[3] || cpu1_irq[3] |-> $past(|node_l17) || $past(|node_l17, 2))
      else $error("level 17 request without pending node");
   a_mchk_both: assert property (
      machine_check_request[0] == machine_check_request[1])
      else $error("machine check differs between cores");
   a_apath_mchk: assert property (
      |(apath_driven & apath_perr) |-> ##[1:3] machine_check_request == 2'b11)
      else $error("address parity error gave no machine check");
   a_dto_pulse: assert property (
      bus_data_timeout |=> !bus_data_timeout)
      else $error("timeout pulse longer than one cycle");
   a_dto_mchk: assert property (
      $rose(bus_data_timeout) |-> ##[0:2] machine_check_request == 2'b11)
      else $error("timeout gave no machine check");
   a_fault_cause: assert property (
      $rose(sys_fault) |-> bus_data_timeout || $past(bus_data_timeout)
         || $past(bus_data_timeout, 2))
      else $error("fault raised without a timeout");
   a_pwr_pass: assert property (
      power_fail_request != 2'b00 |-> $past(power_fail) || $past(power_fail, 2))
      else $error("power fail request without power fail");

   c_timeout: cover property (bus_data_timeout);
   c_mchk: cover property ($rose(machine_check_request[0]));
   c_l17: cover property (cpu0_irq[3]);
endmodule

bind cmie_top cmie_chk u_chk (
   .ref_clk, .rst_n, .reg_re, .reg_rdata, .node_l17, .apath_driven,
   .apath_perr, .power_fail, .cpu0_irq, .cpu1_irq, .machine_check_request,
   .power_fail_request, .bus_data_timeout, .sys_fault
);

`default_nettype wire

// ### dv/cmie_gbus_model.sv
/*
 * General-bus responder: acknowledges a read after a set delay.
 * Assumes read pulses synchronous to ref_clk; delay FF never answers.
 */
`timescale 1ns/100ps
`default_nettype none

module cmie_gbus_model (
   input  wire logic       ref_clk,   // system clock
   input  wire logic       rst_n,     // async reset
   input  wire logic       gbus_read, // read issued
   input  wire logic [7:0] ack_dly,   // cycles to acknowledge
   output var  logic       gbus_ack   // acknowledge pulse
);
   logic [7:0] cnt;
   logic       busy;

   // A slow or dead resource lets the block's timeout run out
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         busy     <= 1'b0;
         cnt      <= 8'h00;
         gbus_ack <= 1'b0;
      end else begin
         gbus_ack <= 1'b0;
         if (gbus_read) begin
            busy <= 1'b1;
            cnt  <= 8'h00;
         end else if (busy && cnt == ack_dly && ack_dly != 8'hFF) begin
            gbus_ack <= 1'b1;
            busy     <= 1'b0;
         end else if (busy) begin
            cnt <= cnt + 8'h01;
         end
      end
   end
endmodule

`default_nettype wire

// ### dv/cmie_top_tb.sv
/*
 * Self-checking bench for the interrupt and error-status block.
 * Assumes cmie_top, its bound checker and the bus responder model.
 */
`timescale 1ns/100ps
`default_nettype none
`include "cmie_defines.vh"

module cmie_top_tb;
   logic        ref_clk, rst_n, reg_we, reg_re, gbus_read, gbus_ack;
   logic        timer_irq, uart_irq, ctlp_halt, secure, power_fail;
   logic        node_reset_write, addr_gate_csr_bus_driven, addr_gate_csr_bus_perr, sys_fault;
   logic        bus_data_timeout;
   logic [15:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic [4:0]  node_l17, node_l16, node_l15, node_l14;
   logic [1:0]  ip_set, halt_write, apath_driven, apath_perr;
   logic [1:0]  machine_check_request, halt_request, power_fail_request;
   logic [4:0]  csr_valid, dm_to_gate, csr_perr;
   logic [3:0]  cpu0_irq, cpu1_irq;
   logic [7:0]  ack_dly;
   int          err_total, n_tests, cyc, dto_cnt, d0;

   // Short timeout so the run stays brief
   cmie_top #(.GENERAL_BUS_TIMEOUT_FLAG_NS(100), .CLK_NS(10)) DUT (
      .ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_we, .reg_re,
      .reg_rdata, .gbus_read, .gbus_ack, .node_l17, .node_l16, .node_l15,
      .node_l14, .timer_irq, .uart_irq, .ip_set, .ctlp_halt, .secure,
      .halt_write, .node_reset_write, .power_fail, .csr_valid, .dm_to_gate,
      .csr_perr, .addr_gate_csr_bus_driven, .addr_gate_csr_bus_perr, .apath_driven, .apath_perr,
      .cpu0_irq, .cpu1_irq, .machine_check_request, .halt_request,
      .power_fail_request, .bus_data_timeout, .sys_fault
   );
   cmie_gbus_model u_gbus (.ref_clk, .rst_n, .gbus_read, .ack_dly, .gbus_ack);

   // Clock, 10 ns period
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // Cycle ceiling and tally of timeout pulses
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (bus_data_timeout === 1'b1) begin
         dto_cnt <= dto_cnt + 1;
      end
      if (cyc == 20000) begin
         err_total = err_total + 1;
         wrap_up;
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests = n_tests + 1;
      if (got !== exp) begin
         err_total = err_total + 1;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_we    <= 1'b1;
      @(posedge ref_clk);
      reg_we    <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe; taken at its end
   task automatic rd(input logic [15:0] a, input logic [31:0] exp);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_re   <= 1'b1;
      @(posedge ref_clk);
      reg_re   <= 1'b0;
      @(posedge ref_clk);
      chk(reg_rdata, exp);
   endtask

   task automatic t_regs;
      rd(`CMIE_OFF_DERR, 32'h0);
      rd(`CMIE_OFF_MERR, 32'h0);
      wr(`CMIE_OFF_EN0, 32'hFFFFFFFF);
      wr(`CMIE_OFF_EN1, 32'h000000AA);
      wr(16'h1000, 32'hFFFFFFFF);
      rd(`CMIE_OFF_EN0, 32'h000001FF);
      rd(`CMIE_OFF_EN1, 32'h000000AA);
      rd(16'h1000, 32'h0);
   endtask

   // Each level alone, enabled on CPU0 only, then on CPU1 only
   task automatic t_levels;
      for (int l = 0; l < 4; l++) begin
         wr(`CMIE_OFF_EN0, 32'h1 << (l + 1));
         wr(`CMIE_OFF_EN1, 32'h0);
         {node_l17, node_l16, node_l15, node_l14} <= 20'h12 << (5 * l);
         rd(`CMIE_OFF_SRC0,
            (32'h12 << (7 + 5 * l)) | (32'h1 << (l + 1)));
         chk({28'h0, cpu0_irq}, 32'h1 << l);
         chk({28'h0, cpu1_irq}, 32'h0);
         wr(`CMIE_OFF_EN0, 32'h0);
         wr(`CMIE_OFF_EN1, 32'h1 << (l + 1));
         rd(`CMIE_OFF_SRC1,
            (32'h12 << (7 + 5 * l)) | (32'h1 << (l + 1)));
         chk({28'h0, cpu0_irq}, 32'h0);
         chk({28'h0, cpu1_irq}, 32'h1 << l);
         {node_l17, node_l16, node_l15, node_l14} <= 20'h0;
      end
   endtask

   task automatic t_w1c;
      wr(`CMIE_OFF_EN0, 32'h00000061);
      @(posedge ref_clk);
      timer_irq <= 1'b1;
      uart_irq  <= 1'b1;
      ip_set    <= 2'b10;
      @(posedge ref_clk);
      {timer_irq, uart_irq, ip_set} <= 4'h0;
      rd(`CMIE_OFF_SRC0, 32'h00000041);
      rd(`CMIE_OFF_SRC1, 32'h00000061);
      chk({28'h0, cpu0_irq}, 32'h1);
      chk({28'h0, cpu1_irq}, 32'h0);
      wr(`CMIE_OFF_SRC0, 32'h00000040);
      rd(`CMIE_OFF_SRC0, 32'h00000001);
      rd(`CMIE_OFF_SRC1, 32'h00000061);
      wr(`CMIE_OFF_SRC1, 32'h00000021);
      rd(`CMIE_OFF_SRC1, 32'h00000040);
      wr(`CMIE_OFF_SRC0, 32'h00000001);
      wr(`CMIE_OFF_SRC1, 32'h00000040);
      rd(`CMIE_OFF_SRC0, 32'h0);
      chk({28'h0, cpu0_irq}, 32'h0);
   endtask

   task automatic t_halt;
      wr(`CMIE_OFF_EN0, 32'h00000180);
      wr(`CMIE_OFF_EN1, 32'h0);
      for (int s = 1; s >= 0; s--) begin
         secure <= s[0];
         ctlp_halt <= 1'b1;
         halt_write <= s[0] ? 2'b10 : 2'b01;
         @(posedge ref_clk);
         {ctlp_halt, halt_write} <= 3'h0;
         rd(`CMIE_OFF_SRC0, s[0] ? 32'h0 : 32'h18000000);
         rd(`CMIE_OFF_SRC1, 32'h0);
         chk({30'h0, halt_request}, s[0] ? 32'h0 : 32'h1);
      end
      wr(`CMIE_OFF_SRC0, 32'h18000000);
      rd(`CMIE_OFF_SRC0, 32'h0);
      power_fail <= 1'b1;
      repeat (3) @(posedge ref_clk);
      chk({30'h0, power_fail_request}, 32'h3);
      power_fail <= 1'b0;
   endtask

   // One error pulse; read, write zero, clear by ones
   task automatic err_case(input logic [20:0] v, input logic [31:0] ed,
                           input logic [31:0] em);
      @(posedge ref_clk);
      {csr_valid, dm_to_gate, csr_perr, addr_gate_csr_bus_driven, addr_gate_csr_bus_perr,
       apath_driven, apath_perr} <= v;
      @(posedge ref_clk);
      {csr_valid, dm_to_gate, csr_perr, addr_gate_csr_bus_driven, addr_gate_csr_bus_perr,
       apath_driven, apath_perr} <= 21'h0;
      rd(`CMIE_OFF_DERR, ed);
      rd(`CMIE_OFF_MERR, em);
      chk({30'h0, machine_check_request},
          (ed | em) != 0 ? 32'h3 : 32'h0);
      wr(`CMIE_OFF_MERR, 32'h0);
      rd(`CMIE_OFF_MERR, em);
      wr(`CMIE_OFF_DERR, ed);
      wr(`CMIE_OFF_MERR, em);
      rd(`CMIE_OFF_DERR, 32'h0);
      rd(`CMIE_OFF_MERR, 32'h0);
   endtask

   task automatic t_errors;
      err_case(21'h10040, 32'h2, 32'h0);
      err_case(21'h00840, 32'h2, 32'h0);
      err_case(21'h00040, 32'h0, 32'h0);
      err_case(21'h20080, 32'h0, 32'h8);
      err_case(21'h02100, 32'h0, 32'h10);
      err_case(21'h80200, 32'h0, 32'h20);
      err_case(21'h70200, 32'h0, 32'h0);
      err_case(21'h100400, 32'h0, 32'h4);
      err_case(21'hF0400, 32'h0, 32'h0);
      err_case(21'h00030, 32'h1, 32'h0);
      err_case(21'h00010, 32'h0, 32'h0);
      err_case(21'h00005, 32'h0, 32'h1);
      err_case(21'h0000A, 32'h0, 32'h2);
      err_case(21'h00006, 32'h0, 32'h0);
      node_reset_write <= 1'b1;
      @(posedge ref_clk);
      node_reset_write <= 1'b0;
      rd(`CMIE_OFF_MERR, 32'h40);
      wr(`CMIE_OFF_MERR, 32'h40);
      rd(`CMIE_OFF_MERR, 32'h0);
   endtask

   // Prompt ack, then two dead reads with and without force-ignore
   task automatic t_general_bus_timeout_flag;
      for (int k = 0; k < 3; k++) begin
         ack_dly <= (k == 0) ? 8'h03 : 8'hFF;
         d0 = dto_cnt;
         wr(`CMIE_OFF_CTL, (k == 1) ? 32'h1 : 32'h0);
         gbus_read <= 1'b1;
         @(posedge ref_clk);
         gbus_read <= 1'b0;
         repeat (20) @(posedge ref_clk);
         rd(`CMIE_OFF_DERR, (k == 0) ? 32'h0 : 32'h4);
         chk({31'h0, sys_fault}, (k == 2) ? 32'h1 : 32'h0);
         chk({30'h0, machine_check_request},
             (k == 0) ? 32'h0 : 32'h3);
         if (k == 2) begin
            chk(32'(dto_cnt - d0), 32'h1);
         end
         wr(`CMIE_OFF_DERR, 32'h4);
      end
   endtask

   task automatic wrap_up;
      if (err_total == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      {rst_n, reg_we, reg_re, gbus_read, timer_irq, uart_irq, ctlp_halt,
       secure, node_reset_write, power_fail, addr_gate_csr_bus_driven, addr_gate_csr_bus_perr} = '0;
      {reg_addr, reg_wdata, node_l17, node_l16, node_l15, node_l14} = '0;
      {ip_set, halt_write, apath_driven, apath_perr} = '0;
      {csr_valid, dm_to_gate, csr_perr} = '0;
      ack_dly = 8'h03;
      {err_total, n_tests, cyc, dto_cnt, d0} = '0;
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      t_regs;
      t_levels;
      t_w1c;
      t_halt;
      t_errors;
      t_general_bus_timeout_flag;
      wrap_up;
   end
endmodule

`default_nettype wire
